// ---- design/dmc_regs.vh ----
// Constants for the debug mode control block: register map, fields, opcodes
`ifndef DMC_REGS_VH
`define DMC_REGS_VH

// Register byte addresses on the plain register port
`define DMC_ADDR_W          8
`define DMC_OFS_CTRL        8'h00
`define DMC_OFS_STATE       8'h04
`define DMC_OFS_EVT         8'h08
`define DMC_OFS_MASK        8'h0c

// debug_control_first fields
`define DMC_CTRL_IDE        0
`define DMC_CTRL_EDE        1
`define DMC_CTRL_W          2
`define DMC_CTRL_RST        2'h0

// Machine state view read on the state register
`define DMC_ST_FROZEN       0
`define DMC_ST_SERVICE      1
`define DMC_ST_WAITMODE     2
`define DMC_ST_TRACE        3
`define DMC_ST_TPWAIT       4
`define DMC_ST_W            5

// Sticky event bits, same layout in status and mask
`define DMC_EV_DBGINT       0
`define DMC_EV_FREEZE       1
`define DMC_EV_WAIT         2
`define DMC_EV_TRACE        3
`define DMC_EV_TPCMD        4
`define DMC_EV_W            5
`define DMC_EV_RST          5'h00

// Test-port command word: opcode above a 32-bit operand
`define DMC_OPC_W           8
`define DMC_DATA_W          32
`define DMC_OPC_STOP        8'h01
`define DMC_OPC_RUN         8'h02
`define DMC_OPC_STEP        8'h03
`define DMC_OPC_STUFF       8'h04
`define DMC_OPC_WRCTRL      8'h05
`define DMC_OPC_WAITON      8'h06
`define DMC_OPC_WAITOFF     8'h07

// Core state machine codes
`define DMC_S_RUN           2'h0
`define DMC_S_FROZEN        2'h1
`define DMC_S_SERVICE       2'h2

`endif

// ---- design/dmc_debug_mode_control.v ----
// Debug mode selection, freeze control and test-port command decoder
`timescale 1ns/1ps
`default_nettype none
`include "dmc_regs.vh"

module dmc_debug_mode_control #(
  parameter CMD_W = `DMC_OPC_W + `DMC_DATA_W
) (
  input  wire                      SYS_CLK,
  input  wire                      SRST,
  // Register port
  input  wire [`DMC_ADDR_W-1:0]    REG_ADDR,
  input  wire [31:0]               REG_WDATA,
  input  wire                      REG_WR,
  input  wire                      REG_RD,
  output reg  [31:0]               REG_RDATA,
  output reg                       IRQ,
  // Core side
  input  wire                      DEBUG_EVENT,
  input  wire                      MSR_DE,
  input  wire                      MSR_DWE,
  input  wire                      USER_STATE,
  input  wire                      CORE_INT_REQ,
  input  wire                      CORE_INT_RETURN,
  output reg                       CORE_FREEZE,
  output reg                       DEBUG_INT,
  output reg                       STEP_PULSE,
  output reg                       STUFF_VALID,
  output reg  [`DMC_DATA_W-1:0]    STUFF_INSN,
  output reg                       PRIV_EXC_SUPPRESS,
  output reg                       BUS_ENABLE,
  output reg                       MMU_PROT_ON,
  output reg                       TRACE_ACTIVE,
  output reg                       TRACE_EVENT,
  // Test port
  input  wire                      TCK,
  input  wire                      TMS,
  input  wire                      TDI,
  output reg                       TDO
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [2:0]                tck_s_q;
  reg  [1:0]                tms_s_q;
  reg  [1:0]                tdi_s_q;
  reg  [CMD_W-1:0]          shift_q;
  reg  [7:0]                bits_q;
  reg  [31:0]               out_q;
  reg                       cmd_go_q;
  reg  [CMD_W-1:0]          cmd_q;
  reg  [`DMC_CTRL_W-1:0]    ctrl_q;
  reg  [`DMC_CTRL_W-1:0]    ctrl_d;
  reg  [`DMC_EV_W-1:0]      evt_q;
  reg  [`DMC_EV_W-1:0]      evt_d;
  reg  [`DMC_EV_W-1:0]      mask_q;
  reg                       tp_wait_q;
  reg  [1:0]                state_q;
  reg  [1:0]                state_d;
  reg                       wait_frz_q;
  reg                       wait_frz_d;
  wire                      cmd_stop;
  wire                      cmd_run;
  wire                      cmd_step;
  wire                      cmd_stuff;
  wire                      cmd_wrctrl;
  wire                      cmd_waiton;
  wire                      cmd_waitoff;
  wire                      wr_ctrl;
  wire                      wr_evt;
  wire                      wr_mask;
  wire                      tck_rise;
  wire                      tck_fall;
  wire [`DMC_OPC_W-1:0]     opc;
  wire [`DMC_DATA_W-1:0]    opd;
  wire                      ide;
  wire                      ede;
  wire                      wait_armed;
  wire                      ev_int;
  wire                      ev_freeze;
  wire                      ev_wait;
  wire                      ev_trace;
  wire                      frozen;
  wire [`DMC_EV_W-1:0]      ev_set;
  wire [`DMC_ST_W-1:0]      state_view;

  // Command decode shared by several processes
  function is_cmd;
    input                  go;
    input [`DMC_OPC_W-1:0] code;
    input [`DMC_OPC_W-1:0] want;
    begin
      is_cmd = go & (code == want);
    end
  endfunction

  // Register write decode shared by the writable registers
  function is_wr;
    input                   wr;
    input [`DMC_ADDR_W-1:0] addr;
    input [`DMC_ADDR_W-1:0] want;
    begin
      is_wr = wr & (addr == want);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Test-port pin synchronisers; first stage feeds only the second
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      tck_s_q <= 3'h0;
      tms_s_q <= 2'h0;
      tdi_s_q <= 2'h0;
    end else begin
      tck_s_q <= {tck_s_q[1:0], TCK};
      tms_s_q <= {tms_s_q[0], TMS};
      tdi_s_q <= {tdi_s_q[0], TDI};
    end
  end

  // Edges found on the synchronised clock (stages two and three)
  assign tck_rise = tck_s_q[1] & ~tck_s_q[2];
  assign tck_fall = ~tck_s_q[1] & tck_s_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Command shifter: LSB first while TMS low, executes on a TCK rise with TMS high
  // after exactly CMD_W bits; a short or long frame is dropped
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      shift_q  <= {CMD_W{1'b0}};
      bits_q   <= 8'h00;
      cmd_go_q <= 1'b0;
      cmd_q    <= {CMD_W{1'b0}};
    end else begin
      cmd_go_q <= 1'b0;
      if (tck_rise) begin
        if (!tms_s_q[1]) begin
          shift_q <= {tdi_s_q[1], shift_q[CMD_W-1:1]};
          // Saturating count keeps an overlong frame from wrapping
          // back to a valid length
          if (bits_q != 8'hff)
            bits_q <= bits_q + 8'h01;
        end else begin
          if (bits_q == CMD_W[7:0]) begin
            cmd_go_q <= 1'b1;
            cmd_q    <= shift_q;
          end
          bits_q <= 8'h00;
        end
      end
    end
  end

  assign opc = cmd_q[CMD_W-1:`DMC_DATA_W];
  assign opd = cmd_q[`DMC_DATA_W-1:0];

  // One-cycle strobes per executed port command; an unknown opcode
  // still counts as executed but acts on nothing
  assign cmd_stop    = is_cmd(cmd_go_q, opc, `DMC_OPC_STOP);
  assign cmd_run     = is_cmd(cmd_go_q, opc, `DMC_OPC_RUN);
  assign cmd_step    = is_cmd(cmd_go_q, opc, `DMC_OPC_STEP);
  assign cmd_stuff   = is_cmd(cmd_go_q, opc, `DMC_OPC_STUFF);
  assign cmd_wrctrl  = is_cmd(cmd_go_q, opc, `DMC_OPC_WRCTRL);
  assign cmd_waiton  = is_cmd(cmd_go_q, opc, `DMC_OPC_WAITON);
  assign cmd_waitoff = is_cmd(cmd_go_q, opc, `DMC_OPC_WAITOFF);

  // Status shifted out on TDO: reloaded while idle, shifted on TCK fall
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      out_q <= 32'h0;
      TDO   <= 1'b0;
    end else begin
      if (tms_s_q[1])
        out_q <= {{(32-`DMC_ST_W-`DMC_CTRL_W){1'b0}}, state_view, ctrl_q};
      else if (tck_fall)
        out_q <= {1'b0, out_q[31:1]};
      TDO <= out_q[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign ide        = ctrl_q[`DMC_CTRL_IDE];
  assign ede        = ctrl_q[`DMC_CTRL_EDE];
  assign wait_armed = ~ide & ~ede & MSR_DWE & tp_wait_q;
  assign frozen     = (state_q == `DMC_S_FROZEN);

  // Software write strobes; the state register takes no writes
  assign wr_ctrl = is_wr(REG_WR, REG_ADDR, `DMC_OFS_CTRL);
  assign wr_evt  = is_wr(REG_WR, REG_ADDR, `DMC_OFS_EVT);
  assign wr_mask = is_wr(REG_WR, REG_ADDR, `DMC_OFS_MASK);

  // Debug interrupt only with the mode enable and DE both set
  assign ev_int    = DEBUG_EVENT & MSR_DE & (ide | ede);
  // External enable wins over wait mode for the same event
  assign ev_freeze = DEBUG_EVENT & ede;
  assign ev_wait   = DEBUG_EVENT & wait_armed & ~ede;
  assign ev_trace  = DEBUG_EVENT & ~ide & ~ede;

  assign state_view = {tp_wait_q, TRACE_ACTIVE, wait_frz_q,
                       (state_q == `DMC_S_SERVICE), frozen};

  ////////////////////////////////////////////////////////////////////////////
  // Control register: both software and test port write it; the test
  // port wins a same-cycle clash, and neither enable touches the other
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
      ctrl_d = REG_WDATA[`DMC_CTRL_W-1:0];
    if (cmd_wrctrl)
      ctrl_d = opd[`DMC_CTRL_W-1:0];
  end

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      ctrl_q    <= `DMC_CTRL_RST;
      tp_wait_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      // Debug wait enable held by the test-port debugger
      if (cmd_waiton)
        tp_wait_q <= 1'b1;
      else if (cmd_waitoff)
        tp_wait_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Freeze state machine
  always @* begin
    state_d    = state_q;
    wait_frz_d = wait_frz_q;
    case (state_q)
      `DMC_S_RUN: begin
        // Port stop or external-mode event first, wait entry second
        if (ev_freeze || cmd_stop) begin
          state_d    = `DMC_S_FROZEN;
          wait_frz_d = 1'b0;
        end else if (ev_wait) begin
          state_d    = `DMC_S_FROZEN;
          wait_frz_d = 1'b1;
        end
      end
      `DMC_S_FROZEN: begin
        // Run or a core interrupt request after a wait freeze leaves; step releases one instruction and stays
        if (cmd_run) begin
          state_d    = `DMC_S_RUN;
          wait_frz_d = 1'b0;
        end else if (wait_frz_q && CORE_INT_REQ) begin
          state_d = `DMC_S_SERVICE;
        end
      end
      `DMC_S_SERVICE: begin
        if (CORE_INT_RETURN)
          state_d = `DMC_S_FROZEN;
      end
      default: begin
        state_d    = `DMC_S_RUN;
        wait_frz_d = 1'b0;
      end
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      state_q    <= `DMC_S_RUN;
      wait_frz_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      wait_frz_q <= wait_frz_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core-facing outputs, all registered
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      CORE_FREEZE       <= 1'b0;
      DEBUG_INT         <= 1'b0;
      STEP_PULSE        <= 1'b0;
      STUFF_VALID       <= 1'b0;
      STUFF_INSN        <= {`DMC_DATA_W{1'b0}};
      PRIV_EXC_SUPPRESS <= 1'b0;
      BUS_ENABLE        <= 1'b0;
      MMU_PROT_ON       <= 1'b0;
      TRACE_ACTIVE      <= 1'b0;
      TRACE_EVENT       <= 1'b0;
    end else begin
      CORE_FREEZE <= (state_d == `DMC_S_FROZEN);
      // One-cycle request to take the debug vector
      DEBUG_INT   <= ev_int;
      STEP_PULSE  <= frozen & cmd_step;
      // Stuffed words go to the core only while it is frozen
      STUFF_VALID <= frozen & cmd_stuff;
      if (frozen && cmd_stuff)
        STUFF_INSN <= opd;
      // A user-state stuffed word must not trap as privileged
      PRIV_EXC_SUPPRESS <= frozen & USER_STATE & cmd_stuff;
      // Bus interface is never gated by freeze
      BUS_ENABLE  <= 1'b1;
      // No debug path bypasses translation and protection
      MMU_PROT_ON <= 1'b1;
      TRACE_ACTIVE <= ~ide & ~ede & ~(MSR_DWE & tp_wait_q);
      TRACE_EVENT  <= ev_trace;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events: a new event wins over a write-one clear
  assign ev_set = {cmd_go_q, ev_trace, ev_wait & (state_q == `DMC_S_RUN),
                   ev_freeze & (state_q == `DMC_S_RUN), ev_int};

  always @* begin
    evt_d = evt_q;
    if (wr_evt)
      evt_d = evt_q & ~REG_WDATA[`DMC_EV_W-1:0];
    evt_d = evt_d | ev_set;
  end

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      evt_q  <= `DMC_EV_RST;
      mask_q <= `DMC_EV_RST;
      IRQ    <= 1'b0;
    end else begin
      evt_q <= evt_d;
      if (wr_mask)
        mask_q <= REG_WDATA[`DMC_EV_W-1:0];
      IRQ <= |(evt_d & (mask_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data appear the cycle after the strobe and only then;
  // the strobe cycle loads the data register directly, so no wait
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `DMC_OFS_CTRL:
          REG_RDATA <= {{(32-`DMC_CTRL_W){1'b0}}, ctrl_q};
        `DMC_OFS_STATE:
          REG_RDATA <= {{(32-`DMC_ST_W){1'b0}}, state_view};
        `DMC_OFS_EVT:
          REG_RDATA <= {{(32-`DMC_EV_W){1'b0}}, evt_q};
        `DMC_OFS_MASK:
          REG_RDATA <= {{(32-`DMC_EV_W){1'b0}}, mask_q};
        default:
          REG_RDATA <= 32'h0;
      endcase
    end else begin
      REG_RDATA <= 32'h0;
    end
  end

endmodule // dmc_debug_mode_control

`default_nettype wire

// ---- test/dmc_monitor.sv ----
// Assertion checker for the debug mode control block
`timescale 1ns/1ps
`default_nettype none
module dmc_monitor (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic DEBUG_EVENT,
  input wire logic MSR_DE,
  input wire logic USER_STATE,
  input wire logic CORE_INT_REQ,
  input wire logic CORE_INT_RETURN,
  input wire logic CORE_FREEZE,
  input wire logic DEBUG_INT,
  input wire logic STUFF_VALID,
  input wire logic PRIV_EXC_SUPPRESS,
  input wire logic BUS_ENABLE,
  input wire logic MMU_PROT_ON,
  input wire logic TRACE_ACTIVE,
  input wire logic TRACE_EVENT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  //////////////////////////////////////////////////////////
  // Interrupt and trace pulses must come from a core event
  property p_dbg_int;
    DEBUG_INT |-> $past(DEBUG_EVENT) && $past(MSR_DE);
  endproperty
  a_dbg_int: assert property (p_dbg_int)
    else $error("debug interrupt without an enabled event");
  property p_trace_evt;
    TRACE_EVENT |-> $past(DEBUG_EVENT) && !DEBUG_INT;
  endproperty
  a_trace_evt: assert property (p_trace_evt)
    else $error("trace event without event or with interrupt");
  // Bus interface and protection stay on once out of reset
  property p_bus;
    !$past(SRST) |-> BUS_ENABLE;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus interface dropped");
  property p_mmu;
    !$past(SRST) |-> MMU_PROT_ON;
  endproperty
  a_mmu: assert property (p_mmu)
    else $error("memory protection dropped");
  // Stuffed instructions only while frozen, suppression only with them
  property p_priv;
    PRIV_EXC_SUPPRESS |-> STUFF_VALID;
  endproperty
  a_priv: assert property (p_priv)
    else $error("suppression without stuffed instruction");
  property p_stuff_frz;
    STUFF_VALID |-> $past(CORE_FREEZE);
  endproperty
  a_stuff_frz: assert property (p_stuff_frz)
    else $error("stuffed instruction while running");
  // Service of an interrupt while frozen ends frozen again
  sequence s_svc_start;
    $fell(CORE_FREEZE) && $past(CORE_INT_REQ);
  endsequence
  property p_refreeze;
    s_svc_start ##[1:40] CORE_INT_RETURN |=> CORE_FREEZE;
  endproperty
  a_refreeze: assert property (p_refreeze)
    else $error("no refreeze after handler return");
  // With all debug modes off an event gives no interrupt
  sequence s_quiet_evt;
    DEBUG_EVENT && TRACE_ACTIVE ##1 TRACE_ACTIVE;
  endsequence
  property p_trace_mode;
    s_quiet_evt |-> !DEBUG_INT;
  endproperty
  a_trace_mode: assert property (p_trace_mode)
    else $error("interrupt while trace mode active");
endmodule // dmc_monitor

bind dmc_debug_mode_control dmc_monitor mon_u (
  .SYS_CLK, .SRST, .DEBUG_EVENT, .MSR_DE, .USER_STATE, .CORE_INT_REQ,
  .CORE_INT_RETURN, .CORE_FREEZE, .DEBUG_INT, .STUFF_VALID,
  .PRIV_EXC_SUPPRESS, .BUS_ENABLE, .MMU_PROT_ON, .TRACE_ACTIVE,
  .TRACE_EVENT
);
`default_nettype wire

// ---- test/dmc_dbg_model.sv ----
// Behavioural test-port debugger that frames commands for the block
`timescale 1ns/1ps
`default_nettype none
module dmc_dbg_model (
  output var logic TCK,
  output var logic TMS,
  output var logic TDI,
  input  wire logic TDO
);
  // Status bits caught from TDO during the latest frame
  logic [6:0] seen;
  // Link clock rests low and select rests high between frames
  initial begin
    seen = 7'h0;
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end
  //////////////////////////////////////////////////////////
  // One 40-bit frame sent LSB first, closed by a select-high edge
  task automatic send(input logic [39:0] w);
    for (int i = 0; i < 40; i++) begin
      TMS = 1'b0;
      TDI = w[i];
      #200 TCK = 1'b1;
      // Mid-bit sample stays clear of the TDO shift after each fall
      #100 if (i < 7) seen[i] = TDO;
      #100 TCK = 1'b0;
    end
    TMS = 1'b1;
    TDI = ~TDI; // Data line carries no stale value
    #200 TCK = 1'b1;
    #200 TCK = 1'b0;
  endtask
endmodule // dmc_dbg_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking testbench for the debug mode control block
`timescale 1ns/1ps
`default_nettype none
`include "dmc_regs.vh"
module tb_top;
  logic        SYS_CLK = '0, SRST = '1, REG_WR = '0, REG_RD = '0;
  logic        DEBUG_EVENT = '0, MSR_DE = '0, MSR_DWE = '0;
  logic        USER_STATE = '0, CORE_INT_REQ = '0, CORE_INT_RETURN = '0;
  logic [7:0]  REG_ADDR = '0;
  logic [31:0] REG_WDATA = '0, insn_q;
  wire  logic [31:0] REG_RDATA, STUFF_INSN;
  wire  logic  IRQ, CORE_FREEZE, DEBUG_INT, STEP_PULSE, STUFF_VALID;
  wire  logic  PRIV_EXC_SUPPRESS, BUS_ENABLE, MMU_PROT_ON;
  wire  logic  TRACE_ACTIVE, TRACE_EVENT, TCK, TMS, TDI, TDO;
  int          err_count = 0, check_count = 0, n_step = 0, n_stuff = 0;
  logic        sup_q, wt;
  logic [2:0]  got;
  // 20 MHz clock
  always #25 SYS_CLK = ~SYS_CLK;
  dmc_debug_mode_control dut_u (
    .SYS_CLK, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .IRQ, .DEBUG_EVENT, .MSR_DE, .MSR_DWE, .USER_STATE, .CORE_INT_REQ,
    .CORE_INT_RETURN, .CORE_FREEZE, .DEBUG_INT, .STEP_PULSE, .STUFF_VALID,
    .STUFF_INSN, .PRIV_EXC_SUPPRESS, .BUS_ENABLE, .MMU_PROT_ON,
    .TRACE_ACTIVE, .TRACE_EVENT, .TCK, .TMS, .TDI, .TDO);
  dmc_dbg_model dbg_u (.TCK, .TMS, .TDI, .TDO);
  // Count core-side pulses from port commands
  always @(posedge SYS_CLK) begin
    if (STEP_PULSE === 1'b1) n_step++;
    if (STUFF_VALID === 1'b1) begin
      n_stuff++;
      insn_q = STUFF_INSN;
      sup_q = PRIV_EXC_SUPPRESS;
    end
  end
  //////////////////////////////////////////////////////////
  // Shared compare, register cycles, core event and port command
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK) REG_WR <= 1'b0;
    // Idle edge keeps a following write from setting the strobe twice
    @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK) REG_RD <= 1'b0;
    @(negedge SYS_CLK) chk(REG_RDATA, e);
    @(posedge SYS_CLK);
  endtask
  task automatic evt(output logic [2:0] r);
    repeat (3) @(posedge SYS_CLK);
    DEBUG_EVENT <= 1'b1;
    @(posedge SYS_CLK) DEBUG_EVENT <= 1'b0;
    @(negedge SYS_CLK) r = {DEBUG_INT, TRACE_EVENT, CORE_FREEZE};
    @(posedge SYS_CLK);
  endtask
  task automatic port(input logic [7:0] o, input logic [31:0] d);
    dbg_u.send({o, d});
    repeat (10) @(posedge SYS_CLK);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #2000000;
    err_count++;
    end_sim;
  end
  //////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge SYS_CLK);
    SRST <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    chk(BUS_ENABLE & MMU_PROT_ON, 32'h1);
    rd(`DMC_OFS_CTRL, 32'h0);
    rd(`DMC_OFS_EVT, 32'h0);
    rd(8'h10, 32'h0);
    wr(`DMC_OFS_STATE, 32'h1f);
    rd(`DMC_OFS_STATE, 32'h8);
    wr(`DMC_OFS_CTRL, 32'h3);
    rd(`DMC_OFS_CTRL, 32'h3);
    $display("Test registers done");
    port(`DMC_OPC_WAITON, 32'h0);
    for (int i = 0; i < 8; i++) begin
      MSR_DE <= i[2];
      MSR_DWE <= i[2];
      wr(`DMC_OFS_CTRL, {30'h0, i[1:0]});
      evt(got);
      wt = (i[1:0] == 2'h0) && i[2];
      chk(got, {i[2] && i[1:0] != 2'h0, i[1:0] == 2'h0, i[1] || wt});
      rd(`DMC_OFS_STATE, {27'h1, i[1:0] == 2'h0 && !i[2], wt, 1'b0, i[1] || wt});
      if (i[1] || wt) port(`DMC_OPC_RUN, 32'h0);
      chk(CORE_FREEZE, 32'h0);
    end
    port(`DMC_OPC_WAITOFF, 32'h0);
    wr(`DMC_OFS_CTRL, 32'h0);
    wr(`DMC_OFS_EVT, 32'h1f);
    wr(`DMC_OFS_MASK, 32'h8);
    rd(`DMC_OFS_EVT, 32'h0);
    evt(got);
    chk(got, 32'h2);
    rd(`DMC_OFS_EVT, 32'h8);
    chk(IRQ, 32'h1);
    wr(`DMC_OFS_MASK, 32'h0);
    rd(`DMC_OFS_MASK, 32'h0);
    chk(IRQ, 32'h0);
    wr(`DMC_OFS_EVT, 32'h8);
    rd(`DMC_OFS_EVT, 32'h0);
    $display("Test modes done");
    USER_STATE <= 1'b1;
    port(`DMC_OPC_STEP, 32'h0);
    port(`DMC_OPC_STUFF, 32'h5a5a0001);
    chk(n_step + n_stuff, 32'h0);
    port(`DMC_OPC_STOP, 32'h0);
    chk(CORE_FREEZE, 32'h1);
    port(`DMC_OPC_STEP, 32'h0);
    chk(dbg_u.seen, 32'h24);
    port(`DMC_OPC_STUFF, 32'h7c0002a6);
    chk({n_step[15:0], n_stuff[15:0]}, 32'h10001);
    chk({sup_q, insn_q[30:0]}, 32'hfc0002a6);
    chk(CORE_FREEZE, 32'h1);
    port(`DMC_OPC_WRCTRL, 32'h1);
    rd(`DMC_OFS_CTRL, 32'h1);
    port(`DMC_OPC_RUN, 32'h0);
    chk(CORE_FREEZE, 32'h0);
    $display("Test port done");
    port(`DMC_OPC_WAITON, 32'h0);
    wr(`DMC_OFS_CTRL, 32'h0);
    evt(got);
    chk(got[0], 32'h1);
    CORE_INT_REQ <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    chk(CORE_FREEZE, 32'h0);
    CORE_INT_REQ <= 1'b0;
    CORE_INT_RETURN <= 1'b1;
    @(posedge SYS_CLK) CORE_INT_RETURN <= 1'b0;
    @(negedge SYS_CLK) chk(CORE_FREEZE, 32'h1);
    @(posedge SYS_CLK);
    port(`DMC_OPC_RUN, 32'h0);
    chk(dbg_u.seen, 32'h54);
    $display("Test wait done");
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
